/* logic/clock_ctl_pkg.sv */
// clock_ctl_pkg: register indices, field positions, reset values, masks and types
// assumes 16-bit registers reached by word index over a 32-bit bus
// Overview of operation
// - micro clock from low-frequency input when select is 0, else buffered high input
// - micro clock divided by 1, 2, 4, 8 or 16 for codes 0 to 4
// - micro divider feeds separate core and peripheral clocks, gated independently
// - signal reference from buffered high input when select is 0, else low input
// - generator input halved for signal core clock, plus two-phase peripheral clock
// - generator fed by pll when enabled, else directly by reference; changeable anytime
// - pll output is reference times multiplier times two over predivide times divider
// - multiplication factor is the 12-bit field plus one, 1 to 4096
// - 7-bit predivider split over both pll registers, divisor field plus one
// - pll path divided by two to the low-power field; changing it keeps lock
// - pll stops in STOP unless the stop-behaviour bit is set
// - disconnect and crystal bits are storage only
// - high clock pin carries buffered high input unless its disable bit holds it low
// - high input buffer disabled only when set and micro clock uses low input
// - clock pin shows micro clock after reset, signal clock when source bit set
// - clock pin held high while its disable bit is set
// - each core enters low-power states by request and leaves on running-peripheral wake
// - in STOP only the interval timer runs; listed peripherals may still wake
// - in DOZE core stops, fixed set runs, others follow programmable enables
// - WAIT stops only the core; signal STOP stops all, inter-core interface wakes
// - watchdog and timer on low input, serial ports on high input; software limits rate
// - signal core held in reset for 16 reference clocks after reset release
// - without high input, signal core stays in reset until low reference selected
`default_nettype none
package clock_ctl_pkg;
	localparam int IDX_W = 16;
	localparam logic [15:0] IDX_PLL_HIGH = 16'hfffc;
	localparam logic [15:0] IDX_PLL_LOW = 16'hfffd;
	localparam logic [15:0] IDX_CLK_SRC = 16'hfffe;
	localparam logic [15:0] IDX_DOZE_EN = 16'hfff8;
	localparam logic [15:0] IDX_PERIPH_OFF = 16'hfff9;
	localparam logic [15:0] IDX_STATUS = 16'hfffa;
	// clock_source_control fields
	localparam int B_REF_SEL = 8;
	localparam int B_HIGH_OUT_DIS = 7;
	localparam int B_OUT_DIS = 6;
	localparam int B_OUT_SRC = 5;
	localparam int B_DIV_LO = 2;
	localparam int B_MICRO_SEL = 1;
	localparam int B_BUF_DIS = 0;
	// pll_control_high fields
	localparam int B_PD_HI = 9;
	localparam int B_PLL_ON = 6;
	localparam int B_PLL_STOP = 5;
	localparam int B_LPD = 0;
	// pll_control_low fields
	localparam int B_PD_LO = 12;
	localparam int B_MF = 0;
	localparam logic [15:0] RST_PLL_HIGH = 16'h0010;
	localparam logic [15:0] RST_PLL_LOW = 16'h0000;
	localparam logic [15:0] RST_CLK_SRC = 16'h0000;
	localparam logic [15:0] MASK_PLL_HIGH = 16'h0eff;
	localparam logic [15:0] MASK_CLK_SRC = 16'h01ff;
	localparam logic [15:0] MASK_DOZE_EN = 16'h0fff;
	localparam logic [15:0] MASK_PERIPH_OFF = 16'h7fff;
	// micro peripherals: 0 protocol timer, 1 qspi, 2 uart, 3 intc, 4 timers,
	// 5 watchdog, 6 interval timer, 7 keypad, 8 inter-core, 9 smart card, 10 debug, 11 ext irq
	localparam int NUM_MP = 12;
	localparam int NUM_DP = 3;
	localparam int P_UART = 2;
	localparam int P_WDOG = 5;
	localparam int P_PIT = 6;
	localparam int P_SCP = 9;
	localparam logic [11:0] DOZE_FIXED = 12'h8c8;
	localparam logic [11:0] STOP_RUN = 12'h040;
	localparam logic [11:0] STOP_WAKE = 12'hd8c;
	// signal peripherals: 0 inter-core, 1 baseband port, 2 audio port
	localparam logic [2:0] DSP_STOP_WAKE = 3'h1;
	localparam logic [4:0] DSP_RST_REFS = 5'h10;
	typedef enum logic [1:0] {M_RUN, M_WAIT, M_DOZE, M_STOP} mcu_mode_t;
	typedef enum logic [1:0] {D_RUN, D_WAIT, D_STOP} dsp_mode_t;
	typedef struct packed {
		logic req;
		mcu_mode_t mode;
	} mcu_sleep_t;
	typedef struct packed {
		logic req;
		dsp_mode_t mode;
	} dsp_sleep_t;
endpackage : clock_ctl_pkg
`default_nettype wire

/* logic/clock_ctl.sv */
// clock_ctl: clock selection, division, pll model and low-power gating for two cores
// assumes clock pins slower than MCLK/2 and same-clock sleep and wake signals
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module clock_ctl import clock_ctl_pkg::*; #(
	parameter int AW = 18
) (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic HIGH_FREQ_CLOCK_IN,
	input wire logic LOW_FREQ_CLOCK_IN,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [AW-1:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire mcu_sleep_t MCU_SLEEP,
	input wire dsp_sleep_t DSP_SLEEP,
	input wire logic [NUM_MP-1:0] MCU_WAKE,
	input wire logic [NUM_DP-1:0] DSP_WAKE,
	output logic HIGH_CLOCK_OUT_PIN,
	output logic CORE_CLOCK_OUT_PIN,
	output logic HF_BUFFER_EN,
	output logic MCU_CORE_CLK,
	output logic MCU_PERIPH_CLK,
	output logic [NUM_MP-1:0] MCU_PERIPH_RUN,
	output logic [3:0] KERNEL_CLK,
	output logic DSP_CORE_CLK,
	output logic DSP_PH1_CLK,
	output logic DSP_PH2_CLK,
	output logic [NUM_DP-1:0] DSP_PERIPH_RUN,
	output logic DSP_RESET_N,
	output logic PLL_RUNNING
);
	logic hf_m, hf_s, lf_m, lf_s;
	logic [15:0] pll_high, pll_low, clk_src, doze_en, periph_off;
	logic ms_act, rs_act, mcu_src_d, ref_d, mcu_clk, dsp_clk;
	logic [2:0] div_act;
	logic [3:0] mcu_cnt, kern_g;
	logic core_g, per_g, osel, dcore_g, dph_g;
	logic [15:0] credit;
	logic [6:0] pre_cnt;
	logic [7:0] df_cnt;
	logic [4:0] rst_cnt;
	mcu_mode_t mcu_state, next_mcu_state;
	dsp_mode_t dsp_state, next_dsp_state;

	function automatic logic tap(input logic [2:0] c, input logic s, input logic [3:0] n);
		case (c)
			3'h0: tap = s;
			3'h1: tap = n[0];
			3'h2: tap = n[1];
			3'h3: tap = n[2];
			default: tap = n[3];
		endcase
	endfunction : tap

	// high input buffer and pins
	wire buf_on = !(clk_src[B_BUF_DIS] && !clk_src[B_MICRO_SEL]);
	wire hf_buf = hf_s && buf_on;
	wire both_low = !hf_buf && !lf_s;

	// micro clock source and divider
	wire mcu_src = ms_act ? hf_buf : lf_s;
	wire mcu_rise = mcu_src && !mcu_src_d;
	wire [3:0] next_mcu_cnt = mcu_cnt + 4'(mcu_rise);
	wire [2:0] div_req = clk_src[B_DIV_LO+:3];
	wire next_mcu = tap(div_act, mcu_src, next_mcu_cnt);
	wire div_ok = !next_mcu && !tap(div_req, mcu_src, next_mcu_cnt);
	wire next_core_g = next_mcu ? core_g : (mcu_state == M_RUN);
	wire next_per_g = next_mcu ? per_g : (mcu_state != M_STOP);

	// micro low-power peripheral enables
	wire [11:0] mode_run = (mcu_state == M_DOZE) ? (DOZE_FIXED | doze_en[11:0]) :
		(mcu_state == M_STOP) ? STOP_RUN : 12'hfff;
	wire [11:0] next_mrun = mode_run & ~periph_off[11:0];
	wire [11:0] mwake_ok = MCU_PERIPH_RUN | ((mcu_state == M_STOP) ? STOP_WAKE : 12'h000);
	wire mcu_wake = |(MCU_WAKE & mwake_ok);

	// kernel clocks: watchdog, interval timer, uart, smart card
	wire [3:0] k_src = {hf_buf, hf_buf, lf_s, lf_s};
	wire [3:0] k_want = {next_mrun[P_SCP], next_mrun[P_UART], next_mrun[P_PIT], next_mrun[P_WDOG]};
	wire [3:0] next_kern_g;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_kern
			assign next_kern_g[gi] = k_src[gi] ? kern_g[gi] : k_want[gi];
		end
	endgenerate

	// signal reference and pll model
	wire ref_lvl = rs_act ? lf_s : hf_buf;
	wire ref_rise = ref_lvl && !ref_d;
	wire pll_on = pll_high[B_PLL_ON] && (dsp_state != D_STOP || pll_high[B_PLL_STOP]);
	wire [12:0] mul = {1'b0, pll_low[B_MF+:12]} + 13'h001;
	wire [16:0] cred_sum = {1'b0, credit} + (ref_rise ? {3'h0, mul, 1'b0} : 17'h00000);
	wire vco_tick = credit != 16'h0000;
	wire [15:0] next_credit = !pll_on ? 16'h0000 :
		cred_sum[16] ? 16'hffff : cred_sum[15:0] - 16'(vco_tick);
	wire [6:0] pd = {pll_high[B_PD_HI+:3], pll_low[B_PD_LO+:4]};
	wire pre_wrap = vco_tick && pre_cnt >= pd;
	wire [7:0] df_lim = ~(8'hff << pll_high[B_LPD+:3]);
	wire df_wrap = pre_wrap && df_cnt >= df_lim;
	wire gen_tick = pll_high[B_PLL_ON] ? df_wrap : ref_rise;
	wire next_dsp = dsp_clk ^ gen_tick;
	wire next_ph1 = next_dsp && dsp_clk;
	wire next_ph2 = !next_dsp && !dsp_clk;
	wire next_dcore_g = next_dsp ? dcore_g : (dsp_state == D_RUN);
	wire next_dph_g = (next_ph1 || next_ph2) ? dph_g : (dsp_state != D_STOP);
	wire [2:0] next_drun = (dsp_state == D_STOP) ? 3'h0 : ~periph_off[14:12];
	wire [2:0] dwake_ok = DSP_PERIPH_RUN | ((dsp_state == D_STOP) ? DSP_STOP_WAKE : 3'h0);
	wire dsp_wake = |(DSP_WAKE & dwake_ok);
	wire [4:0] next_rst_cnt = rst_cnt + 5'((rst_cnt != DSP_RST_REFS) && ref_rise);
	wire next_osel = (next_mcu || next_dsp) ? osel : clk_src[B_OUT_SRC];

	// register bus decode
	wire wb_req = CYC_I && STB_I && !ACK_O;
	wire wr = wb_req && WE_I;
	wire [15:0] idx = ADR_I[IDX_W+1:2];
	wire [15:0] wm = {{8{SEL_I[1]}}, {8{SEL_I[0]}}};
	wire [15:0] wd = DAT_I[15:0] & wm;
	wire [15:0] status = {10'h000, DSP_RESET_N, PLL_RUNNING, 2'(dsp_state), 2'(mcu_state)};
	wire [15:0] rd = (idx == IDX_PLL_HIGH) ? pll_high :
		(idx == IDX_PLL_LOW) ? pll_low :
		(idx == IDX_CLK_SRC) ? clk_src :
		(idx == IDX_DOZE_EN) ? doze_en :
		(idx == IDX_PERIPH_OFF) ? periph_off :
		(idx == IDX_STATUS) ? status : 16'h0000;

	always_comb begin
		next_mcu_state = mcu_state;
		unique case (mcu_state)
			M_RUN: if (MCU_SLEEP.req) next_mcu_state = MCU_SLEEP.mode;
			M_WAIT, M_DOZE, M_STOP: if (mcu_wake) next_mcu_state = M_RUN;
		endcase
	end

	always_comb begin
		next_dsp_state = dsp_state;
		unique case (dsp_state)
			D_RUN: if (DSP_SLEEP.req) next_dsp_state = DSP_SLEEP.mode;
			D_WAIT, D_STOP: if (dsp_wake) next_dsp_state = D_RUN;
			default: next_dsp_state = D_RUN;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			{hf_m, hf_s, lf_m, lf_s} <= 4'h0;
			pll_high <= RST_PLL_HIGH;
			pll_low <= RST_PLL_LOW;
			clk_src <= RST_CLK_SRC;
			doze_en <= 16'h0000;
			periph_off <= 16'h0000;
			ACK_O <= 1'b0;
			DAT_O <= 32'h00000000;
		end else begin
			{hf_m, hf_s, lf_m, lf_s} <= {HIGH_FREQ_CLOCK_IN, hf_m, LOW_FREQ_CLOCK_IN, lf_m};
			if (wr && idx == IDX_PLL_HIGH) pll_high <= (pll_high & ~wm) | (wd & MASK_PLL_HIGH);
			if (wr && idx == IDX_PLL_LOW) pll_low <= (pll_low & ~wm) | wd;
			if (wr && idx == IDX_CLK_SRC) clk_src <= (clk_src & ~wm) | (wd & MASK_CLK_SRC);
			if (wr && idx == IDX_DOZE_EN) doze_en <= (doze_en & ~wm) | (wd & MASK_DOZE_EN);
			if (wr && idx == IDX_PERIPH_OFF) periph_off <= (periph_off & ~wm) | (wd & MASK_PERIPH_OFF);
			ACK_O <= wb_req;
			if (wb_req && !WE_I) DAT_O <= {16'h0000, rd};
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			{ms_act, rs_act, mcu_src_d, ref_d, mcu_clk, dsp_clk} <= 6'h00;
			div_act <= 3'h0;
			mcu_cnt <= 4'h0;
			{core_g, per_g, osel, dcore_g, dph_g} <= 5'h00;
			kern_g <= 4'h0;
			credit <= 16'h0000;
			pre_cnt <= 7'h00;
			df_cnt <= 8'h00;
			rst_cnt <= 5'h00;
			mcu_state <= M_RUN;
			dsp_state <= D_RUN;
		end else begin
			if (both_low) ms_act <= clk_src[B_MICRO_SEL];
			if (both_low) rs_act <= clk_src[B_REF_SEL];
			if (div_ok) div_act <= div_req;
			{mcu_src_d, ref_d, mcu_clk, dsp_clk} <= {mcu_src, ref_lvl, next_mcu, next_dsp};
			mcu_cnt <= next_mcu_cnt;
			{core_g, per_g, osel} <= {next_core_g, next_per_g, next_osel};
			{dcore_g, dph_g} <= {next_dcore_g, next_dph_g};
			kern_g <= next_kern_g;
			credit <= next_credit;
			if (!pll_on) pre_cnt <= 7'h00;
			else if (vco_tick) pre_cnt <= pre_wrap ? 7'h00 : pre_cnt + 7'h01;
			if (pre_wrap) df_cnt <= df_wrap ? 8'h00 : df_cnt + 8'h01;
			rst_cnt <= next_rst_cnt;
			mcu_state <= next_mcu_state;
			dsp_state <= next_dsp_state;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			{HIGH_CLOCK_OUT_PIN, CORE_CLOCK_OUT_PIN, HF_BUFFER_EN} <= 3'h1;
			{MCU_CORE_CLK, MCU_PERIPH_CLK, DSP_CORE_CLK, DSP_PH1_CLK, DSP_PH2_CLK} <= 5'h00;
			MCU_PERIPH_RUN <= 12'hfff;
			DSP_PERIPH_RUN <= 3'h7;
			KERNEL_CLK <= 4'h0;
			DSP_RESET_N <= 1'b0;
			PLL_RUNNING <= 1'b0;
		end else begin
			HIGH_CLOCK_OUT_PIN <= hf_buf && !clk_src[B_HIGH_OUT_DIS];
			CORE_CLOCK_OUT_PIN <= clk_src[B_OUT_DIS] || (next_osel ? next_dsp : next_mcu);
			HF_BUFFER_EN <= buf_on;
			MCU_CORE_CLK <= next_mcu && next_core_g;
			MCU_PERIPH_CLK <= next_mcu && next_per_g;
			MCU_PERIPH_RUN <= next_mrun;
			KERNEL_CLK <= k_src & next_kern_g;
			DSP_CORE_CLK <= next_dsp && next_dcore_g;
			DSP_PH1_CLK <= next_ph1 && next_dph_g;
			DSP_PH2_CLK <= next_ph2 && next_dph_g;
			DSP_PERIPH_RUN <= next_drun;
			DSP_RESET_N <= next_rst_cnt == DSP_RST_REFS;
			PLL_RUNNING <= pll_on;
		end
	end

	AST_MICRO_LOW: assert property (@(posedge MCLK) disable iff (!RESETN)
		(!ms_act && div_act == 3'h0) |=> mcu_clk == $past(lf_s))
		else $error("micro clock not following low input");
	AST_HIGH_PIN_LOW: assert property (@(posedge MCLK) disable iff (!RESETN)
		clk_src[B_HIGH_OUT_DIS] |=> !HIGH_CLOCK_OUT_PIN)
		else $error("high clock pin not held low");
	AST_OUT_PIN_HIGH: assert property (@(posedge MCLK) disable iff (!RESETN)
		clk_src[B_OUT_DIS] |=> CORE_CLOCK_OUT_PIN)
		else $error("clock pin not held high");
	AST_BUFFER_KEPT: assert property (@(posedge MCLK) disable iff (!RESETN)
		clk_src[B_MICRO_SEL] |=> HF_BUFFER_EN)
		else $error("buffer disabled while micro uses high input");
	AST_PLL_STOPPED: assert property (@(posedge MCLK) disable iff (!RESETN)
		(dsp_state == D_STOP && !pll_high[B_PLL_STOP]) |=> !PLL_RUNNING && credit == 16'h0000)
		else $error("pll running in stop");
	AST_BYPASS_HALF: assert property (@(posedge MCLK) disable iff (!RESETN)
		(!pll_high[B_PLL_ON] && ref_rise) |=> dsp_clk != $past(dsp_clk))
		else $error("bypass reference edge did not toggle signal clock");
	AST_MULT: assert property (@(posedge MCLK) disable iff (!RESETN)
		(pll_on && ref_rise && credit == 16'h0000) |=> credit == $past({2'h0, mul, 1'b0}))
		else $error("multiplier credit wrong");
	AST_MCU_STOP: assert property (@(posedge MCLK) disable iff (!RESETN)
		(mcu_state == M_STOP) |=> (MCU_PERIPH_RUN & ~STOP_RUN) == 12'h000)
		else $error("peripheral running in stop");
	AST_DOZE_KEEP: assert property (@(posedge MCLK) disable iff (!RESETN)
		(mcu_state == M_DOZE && (periph_off[11:0] & DOZE_FIXED) == 12'h000)
		|=> (MCU_PERIPH_RUN & DOZE_FIXED) == DOZE_FIXED)
		else $error("fixed doze peripheral stopped");
	AST_DSP_STOP: assert property (@(posedge MCLK) disable iff (!RESETN)
		(dsp_state == D_STOP) |=> DSP_PERIPH_RUN == 3'h0)
		else $error("signal peripheral running in stop");
	AST_DSP_RESET: assert property (@(posedge MCLK) disable iff (!RESETN)
		DSP_RESET_N |-> rst_cnt == DSP_RST_REFS)
		else $error("signal core released early");
	AST_WAKE: assert property (@(posedge MCLK) disable iff (!RESETN)
		(mcu_state != M_RUN && |(MCU_WAKE & MCU_PERIPH_RUN)) |=> mcu_state == M_RUN)
		else $error("running peripheral did not wake micro core");
endmodule : clock_ctl
`default_nettype wire

/* bench/tb_clock_ctl.sv */
// tb_clock_ctl: self-checking bench for clock_ctl
// assumes package and design compiled first; inputs driven at MCLK rise
`timescale 1ns/1ps
`default_nettype none
module tb_clock_ctl
	import clock_ctl_pkg::*;
;
	typedef struct packed {logic chk; logic [15:0] exp;} note_t;
	logic mclk = 0, rst_n = 0, hf = 0, lf = 0, cyc = 0, stb = 0, we = 0;
	logic [17:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0, dat_o;
	mcu_sleep_t msl = '{1'b0, M_RUN};
	dsp_sleep_t dsl = '{1'b0, D_RUN};
	logic [11:0] mwake = '0, mrun;
	logic [2:0] dwake = '0, drun;
	logic [3:0] kclk;
	logic ack, hco, cco, hbe, mcc, mpc, dcc, dp1, dp2, drst_n, pllr;
	int err_count = 0, compares = 0;
	integer seed = 32'hf3309c4e;
	note_t notes[$];
	note_t n;
	clock_ctl #(.AW(18)) u_dut (.MCLK(mclk), .RESETN(rst_n), .HIGH_FREQ_CLOCK_IN(hf),
		.LOW_FREQ_CLOCK_IN(lf), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
		.DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .MCU_SLEEP(msl), .DSP_SLEEP(dsl),
		.MCU_WAKE(mwake), .DSP_WAKE(dwake), .HIGH_CLOCK_OUT_PIN(hco), .CORE_CLOCK_OUT_PIN(cco),
		.HF_BUFFER_EN(hbe), .MCU_CORE_CLK(mcc), .MCU_PERIPH_CLK(mpc), .MCU_PERIPH_RUN(mrun),
		.KERNEL_CLK(kclk), .DSP_CORE_CLK(dcc), .DSP_PH1_CLK(dp1), .DSP_PH2_CLK(dp2),
		.DSP_PERIPH_RUN(drun), .DSP_RESET_N(drst_n), .PLL_RUNNING(pllr));
	initial forever #12.5 mclk = ~mclk;
	initial forever begin
		repeat (4) @(posedge mclk);
		hf <= ~hf;
	end
	initial forever begin
		repeat (40) @(posedge mclk);
		lf <= ~lf;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task results;
		$display("compares=%0d mismatches=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	// one classic cycle; a read notes its expected data for the monitor
	task wb(input logic w, input logic [15:0] idx, input logic [15:0] d, input logic chk);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {16'h0000, d};
		sel <= 4'h3;
		notes.push_back('{chk, d});
		while (ack !== 1'b1) @(posedge mclk);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	always @(posedge mclk) if (ack === 1'b1) begin
		n = notes.pop_front();
		if (n.chk) check(dat_o, {16'h0000, n.exp});
	end
	function logic pick(input int s);
		case (s)
			0: return mcc;
			1: return dcc;
			2: return cco;
			3: return hco;
			5: return kclk[0];
			6: return kclk[2];
			7: return dp1;
			default: return mpc;
		endcase
	endfunction : pick
	task rises(input int s, input int w, output int c);
		logic p;
		p = pick(s);
		c = 0;
		repeat (w) begin
			@(posedge mclk);
			if (pick(s) && !p) c++;
			p = pick(s);
		end
	endtask : rises
	task near(input int s, input int w, input int e);
		int c;
		rises(s, w, c);
		check(32'(c >= e - 1 && c <= e + 1), 32'h1);
		$display("clock %0d rises %0d want %0d", s, c, e);
	endtask : near
	task msleep(input mcu_mode_t m);
		@(posedge mclk) msl <= '{1'b1, m};
		@(posedge mclk) msl <= '{1'b0, M_RUN};
		repeat (6) @(posedge mclk);
	endtask : msleep
	task wake(input logic [11:0] w);
		@(posedge mclk) mwake <= w;
		@(posedge mclk) mwake <= '0;
		repeat (6) @(posedge mclk);
	endtask : wake
	initial begin
		repeat (30000) @(posedge mclk);
		err_count++;
		results();
	end
	initial begin
		int c;
		logic [15:0] r;
		static logic [15:0] hi [4] = '{16'h0010, 16'h0050, 16'h0250, 16'h0051};
		static logic [15:0] lo [4] = '{16'h0000, 16'h0001, 16'h0003, 16'h0001};
		repeat (5) @(posedge mclk);
		check(32'(cco), 32'h0);
		check(32'(mrun), 32'hfff);
		@(posedge mclk) rst_n <= 1'b1;
		repeat (100) @(posedge mclk);
		check(32'(drst_n), 32'h0);
		repeat (60) @(posedge mclk);
		check(32'(drst_n), 32'h1);
		$display("test reset done");
		wb(0, IDX_PLL_HIGH, RST_PLL_HIGH, 1);
		wb(0, IDX_PLL_LOW, RST_PLL_LOW, 1);
		wb(0, IDX_CLK_SRC, RST_CLK_SRC, 1);
		for (int i = 0; i < 4; i++) begin
			r = 16'($random(seed));
			wb(1, IDX_PLL_HIGH, r, 0);
			wb(0, IDX_PLL_HIGH, r & MASK_PLL_HIGH, 1);
			wb(1, IDX_PLL_LOW, ~r, 0);
			wb(0, IDX_PLL_LOW, ~r, 1);
			wb(1, 16'h0001, r, 0);
			wb(0, 16'h0001, 16'h0000, 1);
		end
		wb(1, IDX_PLL_HIGH, RST_PLL_HIGH, 0);
		$display("test registers done");
		near(0, 400, 5);
		near(2, 400, 5);
		near(5, 400, 5);
		for (int d = 0; d < 5; d++) begin
			wb(1, IDX_CLK_SRC, 16'((d << B_DIV_LO) | (1 << B_MICRO_SEL)), 0);
			repeat (256) @(posedge mclk);
			near(0, 512, 64 >> d);
			near(4, 512, 64 >> d);
		end
		$display("test divider done");
		wb(1, IDX_CLK_SRC, 16'h00c2, 0);
		near(2, 200, 0);
		near(3, 200, 0);
		check(32'(cco), 32'h1);
		check(32'(hco), 32'h0);
		wb(1, IDX_CLK_SRC, 16'h0003, 0);
		repeat (4) @(posedge mclk);
		check(32'(hbe), 32'h1);
		wb(1, IDX_CLK_SRC, 16'h0001, 0);
		repeat (4) @(posedge mclk);
		check(32'(hbe), 32'h0);
		wb(1, IDX_CLK_SRC, 16'h0020, 0);
		near(3, 200, 25);
		near(6, 200, 25);
		near(2, 320, 20);
		near(7, 320, 20);
		$display("test pins done");
		for (int k = 0; k < 4; k++) begin
			wb(1, IDX_PLL_HIGH, hi[k], 0);
			wb(1, IDX_PLL_LOW, lo[k], 0);
			repeat (64) @(posedge mclk);
			c = hi[k][6] ? 512 * (lo[k][11:0] + 1) / ((8 * ({hi[k][11:9], lo[k][15:12]} + 1))
				<< hi[k][2:0]) : 32;
			near(1, 512, c);
		end
		$display("test pll done");
		wb(1, IDX_PLL_HIGH, RST_PLL_HIGH, 0);
		wb(1, IDX_CLK_SRC, 16'h0002, 0);
		msleep(M_WAIT);
		check(32'(mrun), 32'hfff);
		near(0, 64, 0);
		wb(0, IDX_STATUS, 16'h0021, 1);
		wake(12'h001);
		near(0, 64, 8);
		r = 16'($random(seed)) & MASK_DOZE_EN;
		wb(1, IDX_DOZE_EN, r, 0);
		msleep(M_DOZE);
		check(32'(mrun), 32'(DOZE_FIXED | r[11:0]));
		near(0, 64, 0);
		wake(12'h008);
		msleep(M_STOP);
		check(32'(mrun), 32'(STOP_RUN));
		wake(12'h001);
		near(0, 64, 0);
		wake(12'h004);
		wb(0, IDX_STATUS, 16'h0020, 1);
		$display("test micro sleep done");
		for (int p = 0; p < 2; p++) begin
			wb(1, IDX_PLL_HIGH, 16'(16'h0050 | (p << B_PLL_STOP)), 0);
			@(posedge mclk) dsl <= '{1'b1, D_STOP};
			@(posedge mclk) dsl <= '{1'b0, D_RUN};
			repeat (6) @(posedge mclk);
			check(32'(drun), 32'h0);
			check(32'(pllr), 32'(p));
			@(posedge mclk) dwake <= 3'h1;
			@(posedge mclk) dwake <= 3'h0;
			repeat (6) @(posedge mclk);
			check(32'(drun), 32'h7);
			check(32'(pllr), 32'h1);
		end
		$display("test signal sleep done");
		results();
	end
endmodule : tb_clock_ctl
`default_nettype wire
